// [rtl/scs_switch_clock.sv]
`timescale 1ns/1ps
`default_nettype none

module scs_switch_clock #(
    parameter int TOL_CYC = 2
) (
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RSTN,
    // Straps and pins
    input  wire logic [1:0]  I_CFG_STRAP,
    input  wire logic [1:0]  I_SYNC_STRAP,
    input  wire logic [4:0]  I_FSR_INDEX,
    input  wire logic        I_EN,
    input  wire logic        I_SYNC_IN,
    output logic             O_SYNC_OUT,
    output logic             O_SYNC_OE_N,
    // Switching clock and status
    output logic             O_SW_CLK,
    output logic [5:0]       O_FSW_N,
    output logic             O_LOCKED,
    output logic             O_CLK_LOST,
    output logic             O_PRECISE_RAMP,
    // AHB-Lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic [31:0]      O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP
);

    typedef struct packed {
        scs_pkg::scs_fsm_type   fsm;
        scs_pkg::scs_strap_type cfg;
        scs_pkg::scs_strap_type sstrap;
        logic [4:0]             sidx;
        logic                   strap_done;
        logic [1:0]             boot;
        logic [1:0]             cfg_q1;
        logic [1:0]             cfg_q2;
        logic [1:0]             ss_q1;
        logic [1:0]             ss_q2;
        logic [4:0]             idx_q1;
        logic [4:0]             idx_q2;
        logic                   en_q1;
        logic                   en_q2;
        logic                   en_q3;
        logic                   sy_q1;
        logic                   sy_q2;
        logic                   sy_q3;
        logic                   seen;
        logic [15:0]            cnt;
        logic [7:0]             meas;
        logic [5:0]             fb_n;
        logic                   lost;
        logic                   locked;
        logic [5:0]             cur_n;
        logic [12:0]            acc;
        logic                   swclk;
        logic                   sync_out;
        logic                   sync_oe_n;
        logic [1:0]             ctrl;
        logic [9:0]             freq;
        logic                   ap_wr;
        logic [7:0]             ap_addr;
        logic [31:0]            hrdata;
    } scs_regs_type;

    localparam logic [15:0] DETECT_LIM = 16'(scs_pkg::DETECT_CYC);
    localparam logic [15:0] MIN_PER    = 16'(scs_pkg::FAST_CYC - TOL_CYC);
    localparam logic [15:0] MAX_PER    = 16'(scs_pkg::SLOW_CYC + TOL_CYC);
    localparam logic [12:0] STEP_NS    = 13'(scs_pkg::CLK_NS);
    localparam logic [1:0]  BOOT_END   = 2'(scs_pkg::BOOT_CYC);

    scs_regs_type s;
    scs_regs_type next_s;

    function automatic logic period_ok(input logic [15:0] p);
        return (p >= MIN_PER) && (p <= MAX_PER);
    endfunction

    logic        rise;
    logic        en_rise;
    logic        addr_ok;
    logic        auto_ok;
    logic [5:0]  strap_n;
    logic [5:0]  prog_n;
    logic [5:0]  own_n;
    logic [12:0] per_ns;
    logic [12:0] acc_inc;
    logic [15:0] lost_lim;
    logic [31:0] rd;

    always_comb begin
        next_s = s;
        rise = 1'b0;
        en_rise = 1'b0;
        addr_ok = 1'b0;
        auto_ok = 1'b0;
        strap_n = scs_pkg::N_DEFAULT;
        prog_n = scs_pkg::N_DEFAULT;
        own_n = scs_pkg::N_DEFAULT;
        per_ns = 13'h0000;
        acc_inc = 13'h0000;
        lost_lim = 16'h0000;
        rd = 32'h00000000;

        // Two-stage synchronisers on every pin
        next_s.cfg_q1 = I_CFG_STRAP;
        next_s.cfg_q2 = s.cfg_q1;
        next_s.ss_q1 = I_SYNC_STRAP;
        next_s.ss_q2 = s.ss_q1;
        next_s.idx_q1 = I_FSR_INDEX;
        next_s.idx_q2 = s.idx_q1;
        next_s.en_q1 = I_EN;
        next_s.en_q2 = s.en_q1;
        next_s.en_q3 = s.en_q2;
        next_s.sy_q1 = I_SYNC_IN;
        next_s.sy_q2 = s.sy_q1;
        next_s.sy_q3 = s.sy_q2;
        en_rise = s.en_q2 & ~s.en_q3;

        // Straps latched once after reset release
        if (!s.strap_done) begin
            if (s.boot == BOOT_END) begin
                next_s.cfg = scs_pkg::scs_strap_type'(s.cfg_q2);
                next_s.sstrap = scs_pkg::scs_strap_type'(s.ss_q2);
                next_s.sidx = s.idx_q2;
                next_s.strap_done = 1'b1;
            end else begin
                next_s.boot = s.boot + 2'h1;
            end
        end

        // Output mode ignores the pin entirely
        rise = s.sy_q2 & ~s.sy_q3 & s.strap_done
               & (s.cfg != scs_pkg::STRAP_HIGH);
        auto_ok = !s.ctrl[scs_pkg::CTRL_PRECISE_BIT];

        case (s.sstrap)
            scs_pkg::STRAP_LOW:  strap_n = scs_pkg::scs_nearest_n(
                                     10'(scs_pkg::FREQ_MIN_KHZ));
            scs_pkg::STRAP_HIGH: strap_n = scs_pkg::scs_nearest_n(
                                     10'(scs_pkg::FREQ_MAX_KHZ));
            scs_pkg::STRAP_RES: begin
                if (int'(s.sidx) <= scs_pkg::FREQUENCY_SET_RESISTOR_LAST) begin
                    strap_n = scs_pkg::scs_nearest_n(
                        scs_pkg::FREQUENCY_SET_RESISTOR_KHZ[s.sidx]);
                end
            end
            default:             strap_n = scs_pkg::N_DEFAULT;
        endcase
        prog_n = scs_pkg::scs_nearest_n(s.freq);

        // Own-oscillator divider choice
        if (s.cfg == scs_pkg::STRAP_HIGH) begin
            own_n = scs_pkg::N_DEFAULT;
        end else if (s.lost) begin
            own_n = s.fb_n;
        end else if (s.ctrl[scs_pkg::CTRL_PROG_BIT]) begin
            own_n = prog_n;
        end else if (s.cfg == scs_pkg::STRAP_OPEN) begin
            own_n = strap_n;
        end

        lost_lim = 16'(s.meas) * 16'(scs_pkg::TIMEOUT_PERIODS);
        if (rise || s.fsm == scs_pkg::ST_DETECT
            || s.fsm == scs_pkg::ST_LOCKED) begin
            next_s.cnt = (s.cnt == 16'hFFFF) ? s.cnt : s.cnt + 16'h0001;
        end

        case (s.fsm)
            scs_pkg::ST_IDLE: begin
                next_s.cur_n = own_n;
                if (en_rise && s.strap_done) begin
                    next_s.lost = 1'b0;
                    next_s.seen = 1'b0;
                    next_s.cnt = 16'h0000;
                    if (s.cfg == scs_pkg::STRAP_LOW) begin
                        next_s.fsm = scs_pkg::ST_DETECT;
                    end else if (s.cfg == scs_pkg::STRAP_OPEN
                                 && auto_ok) begin
                        next_s.fsm = scs_pkg::ST_DETECT;
                    end else begin
                        next_s.fsm = scs_pkg::ST_INTERNAL;
                    end
                end
            end
            scs_pkg::ST_DETECT: begin
                if (rise) begin
                    // Edge cycle counts as one, so cnt is the full period
                    next_s.cnt = 16'h0001;
                    next_s.seen = 1'b1;
                    if (s.seen && period_ok(s.cnt)) begin
                        next_s.meas = s.cnt[7:0];
                        next_s.cur_n = scs_pkg::scs_period_to_n(
                            s.cnt[7:0]);
                        next_s.acc = 13'h0000;
                        next_s.fsm = scs_pkg::ST_LOCKED;
                    end
                end else if (s.cnt >= DETECT_LIM) begin
                    next_s.fsm = scs_pkg::ST_INTERNAL;
                end
            end
            scs_pkg::ST_LOCKED: begin
                if (rise) begin
                    next_s.cnt = 16'h0001;
                    if (period_ok(s.cnt)) begin
                        next_s.meas = s.cnt[7:0];
                        next_s.cur_n = scs_pkg::scs_period_to_n(
                            s.cnt[7:0]);
                    end
                end else if (s.cnt > lost_lim) begin
                    next_s.fb_n = scs_pkg::scs_period_to_n(s.meas);
                    next_s.lost = 1'b1;
                    next_s.fsm = scs_pkg::ST_INTERNAL;
                end
            end
            scs_pkg::ST_INTERNAL: begin
                next_s.cur_n = own_n;
            end
            default: begin
                next_s.fsm = scs_pkg::ST_IDLE;
            end
        endcase
        if (!s.en_q2 && s.fsm != scs_pkg::ST_IDLE) begin
            next_s.fsm = scs_pkg::ST_IDLE;
        end
        next_s.locked = next_s.fsm == scs_pkg::ST_LOCKED;

        // Fractional divider: period is N times 125 ns, counted in ns at 100 ns per clock
        per_ns = 13'(s.cur_n) * 13'(scs_pkg::DIV_REF_NS);
        acc_inc = s.acc + STEP_NS;
        if (s.fsm == scs_pkg::ST_LOCKED && rise) begin
            next_s.acc = 13'h0000;
        end else if (acc_inc >= per_ns) begin
            next_s.acc = acc_inc - per_ns;
        end else begin
            next_s.acc = acc_inc;
        end
        next_s.swclk = next_s.acc < (per_ns >> 1);
        next_s.sync_oe_n = !(s.strap_done
                             && s.cfg == scs_pkg::STRAP_HIGH);
        next_s.sync_out = next_s.swclk & !next_s.sync_oe_n;

        // AHB-Lite data phase write
        if (s.ap_wr) begin
            case (s.ap_addr)
                scs_pkg::REG_CTRL: next_s.ctrl = I_HWDATA[1:0];
                scs_pkg::REG_FREQ: next_s.freq = I_HWDATA[9:0];
                default:           next_s.ctrl = next_s.ctrl;
            endcase
        end
        addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
        next_s.ap_wr = addr_ok & I_HWRITE;
        next_s.ap_addr = I_HADDR[7:0];
        case (I_HADDR[7:0])
            scs_pkg::REG_CTRL: rd[1:0] = next_s.ctrl;
            scs_pkg::REG_FREQ: rd[9:0] = next_s.freq;
            scs_pkg::REG_STATUS: begin
                rd[scs_pkg::STS_N_LSB +: 6] = s.cur_n;
                rd[scs_pkg::STS_STATE_LSB +: 2] = s.fsm;
                rd[scs_pkg::STS_LOCKED_BIT] = s.fsm == scs_pkg::ST_LOCKED;
                rd[scs_pkg::STS_LOST_BIT] = s.lost;
                rd[scs_pkg::STS_CFG_LSB +: 2] = s.cfg;
                rd[scs_pkg::STS_SYNC_LSB +: 2] = s.sstrap;
            end
            default: rd = 32'h00000000;
        endcase
        if (addr_ok && !I_HWRITE) begin
            next_s.hrdata = rd;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s <= '0;
            s.cfg <= scs_pkg::STRAP_LOW;
            s.sstrap <= scs_pkg::STRAP_OPEN;
            s.fsm <= scs_pkg::ST_IDLE;
            s.cur_n <= scs_pkg::N_DEFAULT;
            s.fb_n <= scs_pkg::N_DEFAULT;
            s.sync_oe_n <= 1'b1;
            s.ctrl <= scs_pkg::CTRL_RESET;
            s.freq <= scs_pkg::FREQ_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign O_SYNC_OUT = s.sync_out;
    assign O_SYNC_OE_N = s.sync_oe_n;
    assign O_SW_CLK = s.swclk;
    assign O_FSW_N = s.cur_n;
    assign O_LOCKED = s.locked;
    assign O_CLK_LOST = s.lost;
    assign O_PRECISE_RAMP = s.ctrl[scs_pkg::CTRL_PRECISE_BIT];
    assign O_HRDATA = s.hrdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;

endmodule

`default_nettype wire

// [rtl/scs_pkg.sv]
package scs_pkg;

    // Timing base
    localparam int CLK_NS          = 100;
    localparam int OSC_REF_KHZ     = 8000;
    localparam int DIV_REF_NS      = 1000000 / OSC_REF_KHZ;
    localparam int N_MIN           = 8;
    localparam int N_MAX           = 40;
    localparam logic [5:0] N_DEFAULT = 6'h14;
    localparam int FREQ_MIN_KHZ    = 200;
    localparam int FREQ_MAX_KHZ    = 1000;
    localparam int FAST_NS         = 1000;
    localparam int SLOW_NS         = 5000;
    localparam int FAST_CYC        = (FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOW_CYC        = SLOW_NS / CLK_NS;
    localparam int TIMEOUT_PERIODS = 4;
    localparam int DETECT_CYC      = TIMEOUT_PERIODS * SLOW_CYC;
    localparam int BOOT_CYC        = 3;

    // Register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FREQ   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_PRECISE_BIT   = 0;
    localparam int CTRL_PROG_BIT      = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [9:0] FREQ_RESET = 10'h190;
    localparam int STS_N_LSB          = 0;
    localparam int STS_STATE_LSB      = 8;
    localparam int STS_LOCKED_BIT     = 10;
    localparam int STS_LOST_BIT       = 11;
    localparam int STS_CFG_LSB        = 12;
    localparam int STS_SYNC_LSB       = 14;

    typedef enum logic [1:0] {
        STRAP_LOW  = 2'h0,
        STRAP_OPEN = 2'h1,
        STRAP_HIGH = 2'h2,
        STRAP_RES  = 2'h3
    } scs_strap_type;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'h0,
        ST_DETECT   = 2'h1,
        ST_LOCKED   = 2'h2,
        ST_INTERNAL = 2'h3
    } scs_fsm_type;

    localparam logic [9:0] FREQUENCY_SET_RESISTOR_KHZ [0:16] = '{
        10'h0C8, 10'h0DE, 10'h0F2, 10'h10B, 10'h128, 10'h140,
        10'h16C, 10'h190, 10'h1A5, 10'h1D7, 10'h215, 10'h23B,
        10'h267, 10'h29B, 10'h2D7, 10'h379, 10'h3E8
    };
    localparam int FREQUENCY_SET_RESISTOR_LAST = 16;

    // Divider N whose 8MHz/N lies closest to the requested frequency
    function automatic logic [5:0] scs_nearest_n(input logic [9:0] khz);
        int f;
        int best;
        int best_err;
        int err;
        f = int'(khz);
        if (f < FREQ_MIN_KHZ) f = FREQ_MIN_KHZ;
        if (f > FREQ_MAX_KHZ) f = FREQ_MAX_KHZ;
        best = N_MIN;
        best_err = OSC_REF_KHZ - f * N_MIN;
        if (best_err < 0) best_err = -best_err;
        for (int n = N_MIN + 1; n <= N_MAX; n++) begin
            err = OSC_REF_KHZ - f * n;
            if (err < 0) err = -err;
            if (err * best < best_err * n) begin
                best = n;
                best_err = err;
            end
        end
        return 6'(best);
    endfunction

    // Divider N nearest to a measured period in clock cycles
    function automatic logic [5:0] scs_period_to_n(input logic [7:0] cyc);
        int n;
        n = (int'(cyc) * CLK_NS + DIV_REF_NS / 2) / DIV_REF_NS;
        if (n < N_MIN) n = N_MIN;
        if (n > N_MAX) n = N_MAX;
        return 6'(n);
    endfunction

endpackage

// [tb/scs_switch_clock_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_switch_clock_checker (
    // Clock and reset
    input wire logic       I_MCLK,
    input wire logic       I_RSTN,
    // Watched ports
    input wire logic [1:0] I_CFG_STRAP,
    input wire logic       I_SYNC_IN,
    input wire logic       O_SYNC_OUT,
    input wire logic       O_SYNC_OE_N,
    input wire logic       O_SW_CLK,
    input wire logic [5:0] O_FSW_N,
    input wire logic       O_LOCKED,
    input wire logic       O_CLK_LOST,
    input wire logic       O_PRECISE_RAMP
);
    logic [7:0] gap;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // Cycles since the last sync rise while locked
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) gap <= 8'h00;
        else if ($rose(I_SYNC_IN) || !O_LOCKED) gap <= 8'h00;
        else if (gap != 8'hFF) gap <= gap + 8'h01;
    end
    property p_oe_out;
        $rose(I_RSTN) && I_CFG_STRAP == 2'h2 |-> ##[3:7] !O_SYNC_OE_N; endproperty
    a_oe_out: assert property (p_oe_out) else $error("oe late");
    property p_not_out;
        I_CFG_STRAP != 2'h2 |-> O_SYNC_OE_N; endproperty
    a_not_out: assert property (p_not_out) else $error("oe wrong");
    property p_idle_low;
        O_SYNC_OE_N |-> !O_SYNC_OUT; endproperty
    a_idle_low: assert property (p_idle_low) else $error("out high");
    property p_out_fix;
        !O_SYNC_OE_N |-> O_FSW_N == 6'h14 && !O_LOCKED; endproperty
    a_out_fix: assert property (p_out_fix) else $error("out mode");
    property p_lost_x;
        O_CLK_LOST |-> !O_LOCKED; endproperty
    a_lost_x: assert property (p_lost_x) else $error("lost+lock");
    property p_lost_n;
        $rose(O_CLK_LOST) |=> $stable(O_FSW_N); endproperty
    a_lost_n: assert property (p_lost_n) else $error("fallback n");
    property p_phase;
        O_LOCKED && $rose(I_SYNC_IN) |-> ##[2:6] O_SW_CLK; endproperty
    a_phase: assert property (p_phase) else $error("no align");
    property p_gap;
        gap < 8'hE6; endproperty
    a_gap: assert property (p_gap) else $error("loss late");
    property p_prec;
        O_PRECISE_RAMP && I_CFG_STRAP == 2'h1 |-> !$rose(O_LOCKED); endproperty
    a_prec: assert property (p_prec) else $error("auto lock");
    c_lock: cover property ($rose(O_LOCKED));
    c_lost: cover property ($rose(O_CLK_LOST));
    c_out: cover property (!O_SYNC_OE_N && $rose(O_SYNC_OUT));
endmodule
bind scs_switch_clock scs_switch_clock_checker u_chk (
    .I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_CFG_STRAP(I_CFG_STRAP),
    .I_SYNC_IN(I_SYNC_IN), .O_SYNC_OUT(O_SYNC_OUT), .O_SW_CLK(O_SW_CLK),
    .O_SYNC_OE_N(O_SYNC_OE_N), .O_FSW_N(O_FSW_N), .O_LOCKED(O_LOCKED),
    .O_CLK_LOST(O_CLK_LOST), .O_PRECISE_RAMP(O_PRECISE_RAMP)
);
`default_nettype wire

// [tb/scs_sync_source.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_sync_source #(
    parameter int HALF_NS = 400
) (
    // Control
    input  wire logic i_run,
    // Clock onto the sync net
    output logic      o_clk
);
    // Edges fall between system clock edges; a stopped source rests low
    localparam int SKEW_NS = 30;
    initial begin
        o_clk = 1'b0;
        forever begin
            wait (i_run);
            #(SKEW_NS);
            // Whole periods only
            while (i_run) begin
                o_clk = 1'b1;
                #(HALF_NS);
                o_clk = 1'b0;
                #(HALF_NS);
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb_switching_clock_select_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_switching_clock_select_sync;
    logic        clk = 1'b0, rstn = 1'b0, en = 1'b0, run = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  cfg = 2'h0, sstr = 2'h0, htrans = 2'h0;
    logic [4:0]  fsr = 5'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic        src, s_out, oe_n, sw, locked, lost, prec, hrdy, hresp;
    logic [5:0]  fsw;
    wire logic   pin;
    int          errors = 0, cmp_count = 0, cyc = 0;
    always #50 clk = ~clk;
    assign pin = oe_n ? src : s_out;
    scs_sync_source src_u (.i_run(run), .o_clk(src));
    scs_switch_clock dut_u (
        .I_MCLK(clk), .I_RSTN(rstn), .I_CFG_STRAP(cfg),
        .I_SYNC_STRAP(sstr), .I_FSR_INDEX(fsr), .I_EN(en), .I_SYNC_IN(pin),
        .O_SYNC_OUT(s_out), .O_SYNC_OE_N(oe_n), .O_SW_CLK(sw),
        .O_FSW_N(fsw), .O_LOCKED(locked), .O_CLK_LOST(lost),
        .O_PRECISE_RAMP(prec), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
        .O_HREADYOUT(hrdy), .O_HRESP(hresp)
    );
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic boot(input logic [1:0] c, s, input logic [4:0] f);
        rstn <= 1'b0;
        en <= 1'b0;
        run <= 1'b0;
        cfg <= c;
        sstr <= s;
        fsr <= f;
        tick(4);
        rstn <= 1'b1;
        tick(8);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask
    task automatic wait_n(input logic [5:0] e, input string nm);
        for (int k = 0; k < 400 && fsw !== e; k++) @(posedge clk);
        chk(nm, 32'(e), 32'(fsw));
    endtask
    task automatic wait_hi(input logic s, input string nm);
        for (int k = 0; k < 400 && (s ? lost : locked) !== 1'b1; k++)
            @(posedge clk);
        chk(nm, 32'h1, 32'(s ? lost : locked));
    endtask
    task automatic t_regs();
        boot(2'h0, 2'h1, 5'h00);
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        ahb(1'b0, 8'h04, 32'h0);
        chk("freq_rst", 32'h190, rd);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 8'h04, 32'h32A);
        ahb(1'b1, 8'h00, 32'h2);
        ahb(1'b0, 8'h04, 32'h0);
        chk("freq_rb", 32'h32A, rd);
        en <= 1'b1;
        tick(250);
        wait_n(6'h0A, "n_810");
        ahb(1'b0, 8'h08, 32'h0);
        chk("sts_n", 32'h0A, rd & 32'h3F);
        chk("sts_state", 32'h300, rd & 32'h300);
        ahb(1'b1, 8'h04, 32'h64);
        wait_n(6'h28, "n_min");
        ahb(1'b1, 8'h04, 32'h3FF);
        wait_n(6'h08, "n_max");
        $display("regs done");
    endtask
    task automatic t_out();
        longint t;
        boot(2'h2, 2'h0, 5'h00);
        chk("oe_n", 32'h0, 32'(oe_n));
        chk("out_n", 32'h14, 32'(fsw));
        en <= 1'b1;
        @(posedge pin);
        t = $time;
        repeat (4) @(posedge pin);
        chk("out_period", 32'h2710, 32'($time - t));
        tick(300);
        chk("out_nolock", 32'h0, 32'(locked));
        $display("output done");
    endtask
    task automatic t_in();
        boot(2'h0, 2'h1, 5'h00);
        run <= 1'b1;
        tick(20);
        en <= 1'b1;
        wait_hi(1'b0, "in_lock");
        wait_n(6'h08, "in_n");
        run <= 1'b0;
        wait_hi(1'b1, "loss");
        chk("loss_n", 32'h08, 32'(fsw));
        chk("loss_unlock", 32'h0, 32'(locked));
        en <= 1'b0;
        run <= 1'b1;
        tick(20);
        en <= 1'b1;
        wait_hi(1'b0, "relock");
        chk("lost_clear", 32'h0, 32'(lost));
        $display("input done");
    endtask
    task automatic t_auto();
        // Strap [12:11], resistor index [10:6], expected N [5:0]
        logic [12:0] tab [7] = '{13'h0028, 13'h0814, 13'h1008,
            13'h1828, 13'h19D4, 13'h1A8F, 13'h1C08};
        for (int i = 0; i < 7; i++) begin
            boot(2'h1, tab[i][12:11], tab[i][10:6]);
            en <= 1'b1;
            tick(250);
            wait_n(tab[i][5:0], "auto_n");
        end
        sstr <= 2'h0;
        en <= 1'b0;
        tick(10);
        en <= 1'b1;
        tick(250);
        chk("strap_late", 32'h08, 32'(fsw));
        boot(2'h1, 2'h1, 5'h00);
        run <= 1'b1;
        tick(20);
        en <= 1'b1;
        wait_hi(1'b0, "auto_lock");
        $display("auto done");
    endtask
    task automatic t_prec();
        boot(2'h1, 2'h1, 5'h00);
        run <= 1'b1;
        ahb(1'b1, 8'h00, 32'h1);
        tick(2);
        chk("prec_on", 32'h1, 32'(prec));
        en <= 1'b1;
        tick(300);
        chk("prec_nolock", 32'h0, 32'(locked));
        chk("prec_n", 32'h14, 32'(fsw));
        ahb(1'b1, 8'h00, 32'h0);
        tick(2);
        chk("prec_off", 32'h0, 32'(prec));
        $display("precise done");
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        t_regs();
        t_out();
        t_in();
        t_auto();
        t_prec();
        end_of_test();
    end
endmodule
`default_nettype wire
